//--- shared/fdp_pkg.sv
// shared constants for the discovery-table and power/reset command block
//
// Notes on behaviour
// - exit delay unit code 11b, 64 us
// - wait (count+1) units, 448 us, busy
// - fifteenth word: FFh, pin-disable 0, rest zero
// - status write-mode byte reads F9h
// - non-volatile status kept, needs 06h first
// - 50h enables write, activates volatile copy
// - mixed status bits, write needs enable
// - B7h enters 4-byte mode, no enable
// - dedicated 4-byte set, field 1010_0001b
// - resets return to 3-byte addressing
// - soft reset is 66h then 99h
// - reset pair on current lane width
package fdp_pkg;

  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_WRITE_ENABLE     = 8'h06;
  localparam logic [7:0] CMD_VOL_WRITE_ENABLE = 8'h50;
  localparam logic [7:0] CMD_WRITE_STATUS     = 8'h01;
  localparam logic [7:0] CMD_ENTER_4BYTE      = 8'hb7;
  localparam logic [7:0] CMD_EXIT_4BYTE       = 8'he9;
  localparam logic [7:0] CMD_RESET_ENABLE     = 8'h66;
  localparam logic [7:0] CMD_RESET            = 8'h99;
  localparam logic [7:0] CMD_ENTER_DPD        = 8'hb9;
  localparam logic [7:0] CMD_EXIT_DPD         = 8'hab;

  // ---------------------------------------------------------------
  // lane widths
  // ---------------------------------------------------------------
  localparam logic [1:0] LANES_1 = 2'h0;
  localparam logic [1:0] LANES_2 = 2'h1;
  localparam logic [1:0] LANES_4 = 2'h2;
  localparam logic [1:0] LANES_RESET = LANES_1;

  // ---------------------------------------------------------------
  // register port map
  // ---------------------------------------------------------------
  localparam int         ADDR_W          = 9;
  localparam logic [8:0] ADDR_STATUS     = 9'h000;
  localparam logic [8:0] ADDR_FLAGS      = 9'h001;
  localparam logic [8:0] ADDR_MODE       = 9'h002;
  localparam logic [8:0] ADDR_TABLE_LO   = 9'h136;
  localparam logic [8:0] ADDR_TABLE_HI   = 9'h13f;
  localparam int         TABLE_BYTES     = 10;

  // flag register bit positions
  localparam int FLAG_ADDR4    = 0;
  localparam int FLAG_WEL      = 1;
  localparam int FLAG_VOL_WEL  = 2;
  localparam int FLAG_VOL_ACT  = 3;
  localparam int FLAG_DPD      = 4;
  localparam int FLAG_BUSY     = 5;
  localparam int FLAG_RST_ARM  = 6;

  // ---------------------------------------------------------------
  // discovery table fields
  // ---------------------------------------------------------------
  localparam logic [1:0] DPD_UNIT_CODE   = 2'h3;
  localparam logic [4:0] DPD_UNIT_COUNT  = 5'h06;
  localparam logic [7:0] W15_RESERVED    = 8'hff;
  localparam logic       W15_PIN_DISABLE = 1'b0;
  localparam logic [6:0] SR1_WRITE_MODE  = 7'h79;
  localparam logic       SR1_MODE_RSVD   = 1'b1;
  localparam logic [7:0] ENTER_4B_FIELD  = 8'ha1;
  localparam logic [9:0] EXIT_4B_FIELD   = 10'h3e0;
  localparam logic [5:0] SOFT_RST_FIELD  = 6'h10;

  // table bytes, index 0 is offset 136h
  localparam logic [7:0] TABLE_136 = 8'h80;
  localparam logic [7:0] TABLE_137 = 8'h5c;
  localparam logic [7:0] TABLE_138 = 8'h00;
  localparam logic [7:0] TABLE_139 = 8'h00;
  localparam logic [7:0] TABLE_13A = 8'h00;
  localparam logic [7:0] TABLE_13B = W15_RESERVED;
  localparam logic [7:0] TABLE_13C = {SR1_MODE_RSVD, SR1_WRITE_MODE};
  // exit field straddles two bytes: its bits 1:0 sit above the reset field
  localparam logic [7:0] TABLE_13D = {EXIT_4B_FIELD[1:0], SOFT_RST_FIELD};
  localparam logic [7:0] TABLE_13E = EXIT_4B_FIELD[9:2];
  localparam logic [7:0] TABLE_13F = ENTER_4B_FIELD;

  // ---------------------------------------------------------------
  // status register
  // ---------------------------------------------------------------
  localparam logic [7:0] SR1_VOL_MASK  = 8'h03;
  localparam logic [7:0] SR1_RESET_VAL = 8'h00;
  localparam int         SR1_BUSY_BIT  = 0;
  localparam int         SR1_WEL_BIT   = 1;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS    = 4000;
  localparam int DPD_UNIT_NS      = 64000;
  localparam int DPD_EXIT_NS      = (int'(DPD_UNIT_COUNT) + 1) * DPD_UNIT_NS;
  localparam int DPD_EXIT_CYCLES  = (DPD_EXIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TIMER_W          = 17;

endpackage : fdp_pkg

//--- hw/fdp_wait_timer.sv
// down-counter that holds busy for a loaded number of cycles
`timescale 1ns/100ps
module fdp_wait_timer
  import fdp_pkg::*;
#(
  parameter logic [TIMER_W-1:0] CYCLES = TIMER_W'(DPD_EXIT_CYCLES)
) (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic start_in,
  input  wire logic abort_in,
  output logic      busy_out
);

  logic [TIMER_W-1:0] remain;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in || abort_in) begin
      remain <= '0;
    end else if (start_in) begin
      remain <= CYCLES;
    end else if (remain != '0) begin
      remain <= remain - TIMER_W'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in || abort_in) begin
      busy_out <= 1'b0;
    end else if (start_in) begin
      busy_out <= 1'b1;
    end else begin
      busy_out <= (remain > TIMER_W'(1));
    end
  end

endmodule : fdp_wait_timer

//--- hw/fdp_top.sv
// command interpreter for status write modes, 4-byte addressing, soft reset, power-down
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps
module fdp_top
  import fdp_pkg::*;
#(
  parameter logic [TIMER_W-1:0] DPD_EXIT_WAIT = TIMER_W'(DPD_EXIT_CYCLES)
) (
  input  wire logic              clk_in,
  input  wire logic              rst_b_in,
  input  wire logic              hw_reset_b_in,
  input  wire logic              cmd_valid_in,
  input  wire logic [7:0]        cmd_in,
  input  wire logic [7:0]        cmd_data_in,
  input  wire logic [1:0]        cmd_lanes_in,
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [7:0]        reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic      [7:0]        reg_rdata_out,
  output logic      [7:0]        status_out,
  output logic                   addr_4byte_out,
  output logic                   deep_power_down_out,
  output logic                   busy_out,
  output logic                   soft_reset_out
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] nv_status;
  logic [7:0] vol_status;
  logic       vol_active;
  logic       wel;
  logic       vol_wel;
  logic       addr4;
  logic       deep_power_down;
  logic       reset_armed;
  logic [1:0] mode_lanes;
  logic       timer_busy;

  logic       cmd_take;
  logic       lanes_ok;
  logic       do_soft_reset;
  logic       do_hw_reset;
  logic       volatile_clear;
  logic       exit_dpd_start;
  logic [7:0] eff_status;
  logic [7:0] next_rdata;
  logic [7:0] table_byte [TABLE_BYTES];

  // ---------------------------------------------------------------
  // command acceptance
  // ---------------------------------------------------------------
  // commands during the exit wait are dropped; the host owes the wait anyway
  assign cmd_take = cmd_valid_in && !timer_busy && (!deep_power_down || cmd_in == CMD_EXIT_DPD);

  // reset pair only honoured at the lane width software selected
  assign lanes_ok = (cmd_lanes_in == mode_lanes);

  // reset fires only when armed by the command just before
  assign do_soft_reset = cmd_take && cmd_in == CMD_RESET && reset_armed && lanes_ok;

  assign do_hw_reset = !hw_reset_b_in;

  // volatile state returns to defaults on any reset flavour
  assign volatile_clear = do_soft_reset || do_hw_reset;

  assign exit_dpd_start = cmd_take && deep_power_down && cmd_in == CMD_EXIT_DPD;

  // ---------------------------------------------------------------
  // exit wait after deep power-down
  // ---------------------------------------------------------------
  fdp_wait_timer #(
    .CYCLES   (DPD_EXIT_WAIT)
  ) u_exit_wait (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .start_in (exit_dpd_start),
    .abort_in (do_hw_reset),
    .busy_out (timer_busy)
  );

  // ---------------------------------------------------------------
  // reset-enable arming
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_b_in || volatile_clear) begin
      reset_armed <= 1'b0;
    end else if (cmd_take) begin
      // any other command in between disarms the pair
      reset_armed <= (cmd_in == CMD_RESET_ENABLE) && lanes_ok;
    end
  end

  // ---------------------------------------------------------------
  // write enables
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_b_in || volatile_clear) begin
      wel <= 1'b0;
    end else if (cmd_take && cmd_in == CMD_WRITE_ENABLE) begin
      wel <= 1'b1;
    end else if (cmd_take && cmd_in == CMD_WRITE_STATUS) begin
      wel <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in || volatile_clear) begin
      vol_wel <= 1'b0;
    end else if (cmd_take && cmd_in == CMD_VOL_WRITE_ENABLE) begin
      vol_wel <= 1'b1;
    end else if (cmd_take && cmd_in == CMD_WRITE_STATUS) begin
      vol_wel <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in || volatile_clear) begin
      vol_active <= 1'b0;
    end else if (cmd_take && cmd_in == CMD_VOL_WRITE_ENABLE) begin
      vol_active <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // status register 1
  // ---------------------------------------------------------------
  // the non-volatile copy survives pin and soft resets; only power-on clears it
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      nv_status <= SR1_RESET_VAL;
    end else if (cmd_take && cmd_in == CMD_WRITE_STATUS && wel && !vol_wel) begin
      nv_status <= cmd_data_in & ~SR1_VOL_MASK;
    end
  end

  // volatile copy reloads from the stored value whenever it is not active
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      vol_status <= SR1_RESET_VAL;
    end else if (volatile_clear) begin
      vol_status <= nv_status;
    end else if (cmd_take && cmd_in == CMD_WRITE_STATUS && vol_wel) begin
      vol_status <= cmd_data_in & ~SR1_VOL_MASK;
    end else if (!vol_active) begin
      vol_status <= nv_status;
    end
  end

  // live bits are never stored; they reflect the block itself
  always_comb begin
    eff_status = vol_active ? vol_status : nv_status;
    eff_status[SR1_BUSY_BIT] = timer_busy;
    eff_status[SR1_WEL_BIT] = wel || vol_wel;
  end

  // ---------------------------------------------------------------
  // addressing mode
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_b_in || volatile_clear) begin
      addr4 <= 1'b0;
    end else if (cmd_take && cmd_in == CMD_ENTER_4BYTE) begin
      addr4 <= 1'b1;
    end else if (cmd_take && cmd_in == CMD_EXIT_4BYTE) begin
      addr4 <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // deep power-down
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_b_in || do_hw_reset) begin
      deep_power_down <= 1'b0;
    end else if (exit_dpd_start) begin
      deep_power_down <= 1'b0;
    end else if (cmd_take && cmd_in == CMD_ENTER_DPD) begin
      deep_power_down <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // lane mode register
  // ---------------------------------------------------------------
  // a soft reset drops back to single-lane, the width the block starts in
  always_ff @(posedge clk_in) begin
    if (!rst_b_in || volatile_clear) begin
      mode_lanes <= LANES_RESET;
    end else if (reg_wr_in && reg_addr_in == ADDR_MODE) begin
      if (reg_wdata_in[1:0] == LANES_1 || reg_wdata_in[1:0] == LANES_2 ||
          reg_wdata_in[1:0] == LANES_4) begin
        mode_lanes <= reg_wdata_in[1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // discovery table
  // ---------------------------------------------------------------
  assign table_byte[0] = TABLE_136;
  assign table_byte[1] = TABLE_137;
  assign table_byte[2] = TABLE_138;
  assign table_byte[3] = TABLE_139;
  assign table_byte[4] = TABLE_13A;
  assign table_byte[5] = TABLE_13B;
  assign table_byte[6] = TABLE_13C;
  assign table_byte[7] = TABLE_13D;
  assign table_byte[8] = TABLE_13E;
  assign table_byte[9] = TABLE_13F;

  // ---------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    if (reg_addr_in == ADDR_STATUS) begin
      next_rdata = eff_status;
    end else if (reg_addr_in == ADDR_FLAGS) begin
      next_rdata[FLAG_ADDR4]   = addr4;
      next_rdata[FLAG_WEL]     = wel;
      next_rdata[FLAG_VOL_WEL] = vol_wel;
      next_rdata[FLAG_VOL_ACT] = vol_active;
      next_rdata[FLAG_DPD]     = deep_power_down;
      next_rdata[FLAG_BUSY]    = timer_busy;
      next_rdata[FLAG_RST_ARM] = reset_armed;
    end else if (reg_addr_in == ADDR_MODE) begin
      next_rdata = {6'h00, mode_lanes};
    end else if (reg_addr_in >= ADDR_TABLE_LO && reg_addr_in <= ADDR_TABLE_HI) begin
      next_rdata = table_byte[4'(reg_addr_in - ADDR_TABLE_LO)];
    end
  end

  // data only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= next_rdata;
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      status_out <= SR1_RESET_VAL;
    end else begin
      status_out <= eff_status;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      addr_4byte_out      <= 1'b0;
      deep_power_down_out <= 1'b0;
      busy_out            <= 1'b0;
    end else begin
      addr_4byte_out      <= addr4;
      deep_power_down_out <= deep_power_down;
      busy_out            <= timer_busy;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      soft_reset_out <= 1'b0;
    end else begin
      soft_reset_out <= do_soft_reset;
    end
  end

endmodule : fdp_top

//--- tb/fdp_host_model.sv
// host controller model that issues decoded commands to the block
`timescale 1ns/100ps
module fdp_host_model
  import fdp_pkg::*;
(
  input  wire logic  clk_in,
  output logic       cmd_valid_out,
  output logic [7:0] cmd_out,
  output logic [7:0] cmd_data_out,
  output logic [1:0] cmd_lanes_out
);
  initial begin
    cmd_valid_out = 1'b0;
    cmd_out       = 8'h00;
    cmd_data_out  = 8'h00;
    cmd_lanes_out = LANES_1;
  end
  // hold keeps valid up so a follower goes back to back
  task automatic send(input logic [7:0] c, input logic [7:0] d, input logic [1:0] l,
                      input bit hold = 1'b0);
    cmd_valid_out <= 1'b1;
    cmd_out       <= c;
    cmd_data_out  <= d;
    cmd_lanes_out <= l;
    @(posedge clk_in);
    if (!hold) begin
      cmd_valid_out <= 1'b0;
      cmd_out       <= ~c;
      cmd_data_out  <= ~d;
    end
    #1;
  endtask : send
  task automatic nv_write(input logic [7:0] d);
    send(CMD_WRITE_ENABLE, 8'h00, LANES_1, 1'b1);
    send(CMD_WRITE_STATUS, d, LANES_1);
  endtask : nv_write
  task automatic vol_write(input logic [7:0] d);
    send(CMD_VOL_WRITE_ENABLE, 8'h00, LANES_1, 1'b1);
    send(CMD_WRITE_STATUS, d, LANES_1);
  endtask : vol_write
  task automatic reset_pair(input logic [1:0] l);
    send(CMD_RESET_ENABLE, 8'h00, l, 1'b1);
    send(CMD_RESET, 8'h00, l);
  endtask : reset_pair
endmodule : fdp_host_model

//--- tb/fdp_top_sva.sv
// port checker for the command interpreter
`timescale 1ns/100ps
module fdp_top_sva
  import fdp_pkg::*;
#(
  parameter logic [TIMER_W-1:0] DPD_EXIT_WAIT = TIMER_W'(DPD_EXIT_CYCLES)
) (
  input wire logic       clk_in,
  input wire logic       rst_b_in,
  input wire logic       hw_reset_b_in,
  input wire logic       cmd_valid_in,
  input wire logic [7:0] cmd_in,
  input wire logic [7:0] cmd_data_in,
  input wire logic [1:0] cmd_lanes_in,
  input wire logic [8:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [7:0] status_out,
  input wire logic       addr_4byte_out,
  input wire logic       deep_power_down_out,
  input wire logic       busy_out,
  input wire logic       soft_reset_out
);
  logic [TIMER_W-1:0] run_cnt;
  logic [1:0]         mode_q;
  logic               quiet_q;
  logic               arm_q;
  logic               ok;
  assign ok = quiet_q && !busy_out && !deep_power_down_out && hw_reset_b_in;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // busy and power-down flags lag the hidden state by a cycle
  always_ff @(posedge clk_in) begin
    if (!rst_b_in)
      quiet_q <= 1'b1;
    else
      quiet_q <= !(cmd_valid_in && (cmd_in == CMD_ENTER_DPD || cmd_in == CMD_EXIT_DPD));
  end
  always_ff @(posedge clk_in) begin
    if (!rst_b_in || !busy_out)
      run_cnt <= '0;
    else
      run_cnt <= run_cnt + TIMER_W'(1);
  end
  // the design drops lanes an edge before the pulse shows, so a write beside it wins
  always_ff @(posedge clk_in) begin
    if (!rst_b_in || !hw_reset_b_in)
      mode_q <= LANES_RESET;
    else if (reg_wr_in && reg_addr_in == ADDR_MODE && reg_wdata_in[1:0] != 2'h3)
      mode_q <= reg_wdata_in[1:0];
    else if (soft_reset_out)
      mode_q <= LANES_RESET;
  end
  // may be armed: only a surely taken other command disarms, gaps keep the arm
  always_ff @(posedge clk_in) begin
    if (!rst_b_in)
      arm_q <= 1'b0;
    else if (cmd_valid_in && (cmd_in == CMD_RESET_ENABLE || ok))
      arm_q <= (cmd_in == CMD_RESET_ENABLE);
  end
  a_mode_byte: assert property (reg_rd_in && reg_addr_in == 9'h13c |=> reg_rdata_out == 8'hf9)
    else $error("write mode byte wrong");
  a_word15_top: assert property (reg_rd_in && reg_addr_in == 9'h13b |=> reg_rdata_out == 8'hff)
    else $error("word 15 top byte wrong");
  a_enter_4byte: assert property (cmd_valid_in && cmd_in == CMD_ENTER_4BYTE && ok
    |-> ##2 addr_4byte_out) else $error("4-byte entry missed");
  a_hw_exit_4byte: assert property (!hw_reset_b_in |-> ##2 !addr_4byte_out)
    else $error("4-byte kept over reset");
  a_soft_pair: assert property (cmd_valid_in && cmd_in == CMD_RESET_ENABLE && ok
    && !soft_reset_out && cmd_lanes_in == mode_q ##1 cmd_valid_in && cmd_in == CMD_RESET && ok
    && cmd_lanes_in == mode_q |=> soft_reset_out) else $error("soft reset missed");
  a_soft_clears: assert property (soft_reset_out |=> !addr_4byte_out && !status_out[1])
    else $error("soft reset left state");
  a_stray_reset: assert property (cmd_valid_in && cmd_in == CMD_RESET && !arm_q
    |=> !soft_reset_out) else $error("unarmed reset ran");
  a_vol_enable: assert property (cmd_valid_in && cmd_in == CMD_VOL_WRITE_ENABLE && ok
    |-> ##2 status_out[SR1_WEL_BIT]) else $error("volatile enable missed");
  a_exit_wait: assert property ($fell(busy_out) |-> run_cnt == DPD_EXIT_WAIT)
    else $error("exit wait length wrong");
  a_busy_refuse: assert property (busy_out && cmd_valid_in && cmd_in == CMD_ENTER_4BYTE
    && !addr_4byte_out ##1 busy_out |=> !addr_4byte_out) else $error("command taken while busy");
  c_soft: cover property (soft_reset_out);
  c_busy: cover property ($rose(busy_out));
  c_addr4: cover property ($rose(addr_4byte_out));
endmodule : fdp_top_sva

bind fdp_top fdp_top_sva #(.DPD_EXIT_WAIT(DPD_EXIT_WAIT)) u_sva (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .hw_reset_b_in(hw_reset_b_in),
  .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .cmd_data_in(cmd_data_in),
  .cmd_lanes_in(cmd_lanes_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .status_out(status_out), .addr_4byte_out(addr_4byte_out),
  .deep_power_down_out(deep_power_down_out), .busy_out(busy_out),
  .soft_reset_out(soft_reset_out));

//--- tb/fdp_top_tb.sv
// self-checking bench for the command interpreter
`timescale 1ns/100ps
module fdp_top_tb import fdp_pkg::*;;
  localparam logic [TIMER_W-1:0] WAIT_CYC = TIMER_W'(20);
  logic       clk_in, rst_b_in, hw_reset_b_in, cmd_valid_in, reg_wr_in, reg_rd_in;
  logic       addr_4byte_out, deep_power_down_out, busy_out, soft_reset_out;
  logic [7:0] cmd_in, cmd_data_in, reg_wdata_in, reg_rdata_out, status_out, d, nv;
  logic [1:0] cmd_lanes_in;
  logic [8:0] reg_addr_in;
  int         mismatches, compares, cyc, n;
  logic [7:0] tbl [10] = '{8'h80, 8'h5c, 8'h00, 8'h00, 8'h00, 8'hff, 8'hf9, 8'h10, 8'hf8, 8'ha1};

  fdp_host_model host (.clk_in(clk_in), .cmd_valid_out(cmd_valid_in), .cmd_out(cmd_in),
    .cmd_data_out(cmd_data_in), .cmd_lanes_out(cmd_lanes_in));
  fdp_top #(.DPD_EXIT_WAIT(WAIT_CYC)) dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .hw_reset_b_in(hw_reset_b_in),
    .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .cmd_data_in(cmd_data_in),
    .cmd_lanes_in(cmd_lanes_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .status_out(status_out), .addr_4byte_out(addr_4byte_out),
    .deep_power_down_out(deep_power_down_out), .busy_out(busy_out),
    .soft_reset_out(soft_reset_out));

  // live bits are not stored
  function automatic logic [7:0] sr_exp(input logic [7:0] v);
    return v & ~SR1_VOL_MASK;
  endfunction : sr_exp
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic step();
    @(posedge clk_in);
    #1;
  endtask : step
  task automatic op(input logic [7:0] c, input bit h = 1'b0);
    host.send(c, 8'h00, LANES_1, h);
  endtask : op
  task automatic wr(input logic [8:0] a, input logic [7:0] v);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= v;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask : wr
  task automatic rdc(input logic [8:0] a, input logic [7:0] exp);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out, exp);
  endtask : rdc
  task automatic hw_pulse();
    hw_reset_b_in <= 1'b0;
    @(posedge clk_in);
    hw_reset_b_in <= 1'b1;
    // registered outputs show the reset one edge later
    @(posedge clk_in);
    #1;
  endtask : hw_pulse
  task automatic results();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  // whole run needs well under a thousand cycles
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      results();
    end
  end

  initial begin
    void'($urandom(14));
    rst_b_in = 1'b0;
    hw_reset_b_in = 1'b1;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 9'h000;
    reg_wdata_in = 8'h00;
    mismatches = 0;
    compares = 0;
    cyc = 0;
    repeat (20) @(posedge clk_in);
    rst_b_in <= 1'b1;
    step();
    for (int i = 0; i < 30; i++) begin
      n = (i < 10) ? i : $urandom_range(9);
      rdc(9'h136 + 9'(n), tbl[n]);
    end
    rdc(9'h140, 8'h00);
    op(CMD_ENTER_4BYTE);
    step();
    chk(8'(addr_4byte_out), 8'h01);
    hw_pulse();
    chk(8'(addr_4byte_out), 8'h00);
    op(CMD_ENTER_4BYTE);
    host.reset_pair(LANES_1);
    chk(8'(soft_reset_out), 8'h01);
    step();
    chk(8'(addr_4byte_out), 8'h00);
    op(CMD_ENTER_4BYTE);
    op(CMD_RESET_ENABLE, 1'b1);
    op(CMD_WRITE_ENABLE, 1'b1);
    op(CMD_RESET);
    chk(8'(soft_reset_out), 8'h00);
    chk(8'(addr_4byte_out), 8'h01);
    for (int l = 0; l < 6; l++) begin
      d = 8'($urandom_range(2));
      wr(ADDR_MODE, d);
      host.reset_pair(l < 4 ? d[1:0] : d[1:0] ^ 2'h1);
      chk(8'(soft_reset_out), 8'(l < 4));
    end
    wr(ADDR_MODE, 8'h03);
    rdc(ADDR_MODE, d);
    wr(ADDR_MODE, 8'h00);
    host.send(CMD_WRITE_STATUS, 8'hfc, LANES_1);
    step();
    chk(status_out, 8'h00);
    repeat (3) begin
      d = 8'($urandom);
      host.nv_write(d);
      nv = sr_exp(d);
      step();
      chk(status_out, nv);
    end
    hw_pulse();
    chk(status_out, nv);
    d = 8'($urandom);
    host.vol_write(d);
    step();
    chk(status_out, sr_exp(d));
    hw_pulse();
    chk(status_out, nv);
    op(CMD_ENTER_DPD);
    step();
    chk(8'(deep_power_down_out), 8'h01);
    op(CMD_ENTER_4BYTE);
    op(CMD_EXIT_DPD);
    n = 0;
    for (int k = 0; k < 200 && (k < 2 || busy_out); k++) begin
      if (k == 4)
        op(CMD_ENTER_4BYTE);
      else
        step();
      n += int'(busy_out);
    end
    chk(8'(n), 8'(WAIT_CYC));
    chk(8'(addr_4byte_out), 8'h00);
    op(CMD_ENTER_4BYTE);
    step();
    chk(8'(addr_4byte_out), 8'h01);
    rdc(ADDR_FLAGS, 8'h01);
    rdc(ADDR_STATUS, nv);
    op(CMD_EXIT_4BYTE);
    step();
    chk(8'(addr_4byte_out), 8'h00);
    results();
  end
endmodule : fdp_top_tb
